// >>> common/pmx_pkg.sv
// Constants shared by both ends of the power mux serial status link.
// Assumes a 125 MHz core clock on both ends.
package pmx_pkg;

  // Slave address: fixed upper part, strap gives the two low bits
  localparam logic [4:0] ADDR_FIXED_HI = 5'h10;

  // Register map of the device
  localparam logic [7:0] STATUS_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_RESET  = 8'h00;
  localparam int         BIT_HV_OC     = 7;
  localparam int         BIT_REVERSE   = 6;
  localparam int         BIT_LOWV_OC   = 5;
  localparam int         BIT_OVERVOLT  = 4;
  localparam int         BIT_ROLE_SWAP = 3;
  localparam int         BIT_THERMAL   = 2;
  localparam int         BIT_IN_5V_WIN = 1;
  localparam int         BIT_NEAR_ZERO = 0;

  // Timing
  localparam int CLK_FREQ_KHZ = 125000;
  localparam int SCL_MAX_KHZ  = 400;
  // Half period rounded up so the bus never runs above the limit
  localparam int SCL_HALF_CYC = (CLK_FREQ_KHZ + 2 * SCL_MAX_KHZ - 1) / (2 * SCL_MAX_KHZ);

  // Host register map (Wishbone byte addresses)
  localparam logic [3:0] HOST_CMD_OFS  = 4'h0;
  localparam logic [3:0] HOST_TXD_OFS  = 4'h4;
  localparam logic [3:0] HOST_STAT_OFS = 4'h8;
  localparam int         CMD_START     = 0;
  localparam int         CMD_STOP      = 1;
  localparam int         CMD_WRITE     = 2;
  localparam int         CMD_READ      = 3;
  localparam int         CMD_NACK      = 4;
  localparam int         STAT_BUSY     = 0;
  localparam int         STAT_ACKED    = 1;

endpackage

// >>> common/pmx_i2c_if.sv
// Two-wire link between the host end and the device end.
// Both lines are open drain with a pull-up: an enable pulls the wire low.
`timescale 1ns/1ns
interface pmx_i2c_if;
  logic scl;
  logic sda;
  logic sclHostOut;
  logic sclHostOe;
  logic sdaHostOut;
  logic sdaHostOe;
  logic sdaDevOut;
  logic sdaDevOe;

  // Wired-AND with pull-up
  assign scl = ~(sclHostOe & ~sclHostOut);
  assign sda = ~((sdaHostOe & ~sdaHostOut) | (sdaDevOe & ~sdaDevOut));

  modport device (input scl, input sda, output sdaDevOut, output sdaDevOe);
  modport host (input scl, input sda, output sclHostOut, output sclHostOe,
                output sdaHostOut, output sdaHostOe);
endinterface

// >>> rtl/pmx_i2c_dev.sv
// Device end: serial slave with pointer and the protection status register.
// Assumes monitor inputs are asynchronous levels from comparators; writes
// to pointers other than the status register go out to external registers.
//
// Decided for this implementation: the strobe interface to the external registers.
`timescale 1ns/1ns
module pmx_i2c_dev
  import pmx_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Serial link
  pmx_i2c_if.device       link,
  // Strap, supply and sequencer
  input  wire logic [1:0] addrStrap,
  input  wire logic       supplyOk,
  input  wire logic       seqBusy,
  // Analog monitors
  input  wire logic       hvOverCurrent,
  input  wire logic       reverseCond,
  input  wire logic       lowvOverCurrent,
  input  wire logic       busOver6v,
  input  wire logic       busOverThresh,
  input  wire logic       hvChannelSel,
  input  wire logic       busBelowSwap,
  input  wire logic       swapEnable,
  input  wire logic       dieHot,
  input  wire logic       dieCooled,
  input  wire logic       busIn5vWindow,
  input  wire logic       busNearZero,
  input  wire logic       reverseAlertMask,
  // Status and power control
  output logic            alert_n,
  output logic            powerOff,
  output logic            roleSwapPulse,
  output logic [7:0]      protectionStatus,
  // External control registers
  output logic            regWrStrobe,
  output logic [7:0]      regWrAddr,
  output logic [7:0]      regWrData,
  input  wire logic [7:0] regRdData
);

  typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_TX} pmx_dev_state_t;

  localparam int SYNC_W = 19;

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [SYNC_W-1:0] syncA_reg;
  logic [SYNC_W-1:0] syncB_reg;
  logic              sclPrev_reg;
  logic              sdaPrev_reg;
  logic              swapPrev_reg;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      // Idle levels: wires high, monitors quiet, so no false flag after reset
      syncA_reg <= {2'h3, 17'h0_0000};
      syncB_reg <= {2'h3, 17'h0_0000};
    end else begin
      syncA_reg <= {link.scl, link.sda, addrStrap, supplyOk, seqBusy, hvOverCurrent,
                    reverseCond, lowvOverCurrent, busOver6v, busOverThresh, hvChannelSel,
                    busBelowSwap, swapEnable, dieHot, dieCooled, busIn5vWindow,
                    busNearZero, reverseAlertMask};
      syncB_reg <= syncA_reg;
    end
  end

  logic       sclS, sdaS, readyS, busyS, hvOcS, revS, lvOcS, ov6S, ovThS, hvSelS;
  logic       swapS, swapEnS, hotS, cooledS, winS, zeroS, maskS;
  logic [1:0] strapS;
  assign {sclS, sdaS, strapS, readyS, busyS, hvOcS, revS, lvOcS, ov6S, ovThS, hvSelS,
          swapS, swapEnS, hotS, cooledS, winS, zeroS, maskS} = syncB_reg;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sclPrev_reg  <= 1'b1;
      sdaPrev_reg  <= 1'b1;
      swapPrev_reg <= 1'b0;
    end else begin
      sclPrev_reg  <= sclS;
      sdaPrev_reg  <= sdaS;
      swapPrev_reg <= swapS & swapEnS;
    end
  end

  logic sclRise, sclFall, startSeen, stopSeen;
  assign sclRise   = sclS & ~sclPrev_reg;
  assign sclFall   = ~sclS & sclPrev_reg;
  assign startSeen = sclS & sclPrev_reg & sdaPrev_reg & ~sdaS;
  assign stopSeen  = sclS & sclPrev_reg & ~sdaPrev_reg & sdaS;

  ////////////////////////////////////////////////////////////////////////
  // Protection status flags
  logic [7:2] flags_reg;
  logic [7:2] condNow;
  logic [7:2] condGone;
  logic       ovpNow;
  logic       swapEvent;
  logic       statusRdClr;

  assign ovpNow    = hvSelS ? ovThS : ov6S;
  assign swapEvent = swapS & swapEnS & ~swapPrev_reg;
  assign condNow   = {hvOcS, revS, lvOcS, ovpNow, swapEvent, hotS};
  // clear only once cause is gone
  assign condGone  = {~hvOcS, ~revS, ~lvOcS, ~ovpNow, 1'b1, cooledS};

  // Set wins over a clearing read in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      flags_reg <= STATUS_RESET[7:2];
    end else begin
      flags_reg <= condNow | (flags_reg & ~({6{statusRdClr}} & condGone));
    end
  end

  assign protectionStatus = {flags_reg, winS, zeroS};

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      alert_n       <= 1'b1;
      powerOff      <= 1'b0;
      roleSwapPulse <= 1'b0;
    end else begin
      alert_n       <= ~(flags_reg[BIT_HV_OC] | (flags_reg[BIT_REVERSE] & ~maskS) |
                         flags_reg[BIT_LOWV_OC] | flags_reg[BIT_ROLE_SWAP] |
                         flags_reg[BIT_THERMAL]);
      powerOff      <= flags_reg[BIT_HV_OC] | flags_reg[BIT_OVERVOLT] |
                       flags_reg[BIT_THERMAL];
      roleSwapPulse <= swapEvent;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial slave
  pmx_dev_state_t state_reg;
  logic [3:0]     bitCnt_reg;
  logic [1:0]     byteNum_reg;
  logic [7:0]     shift_reg;
  logic [7:0]     pointer_reg;
  logic           inAck_reg;
  logic           isRead_reg;
  logic           masterAck_reg;
  logic           sdaOe_reg;
  logic [6:0]     ownAddr;
  logic [7:0]     readByte;
  logic           addrMatch;

  assign ownAddr   = {ADDR_FIXED_HI, strapS};
  assign addrMatch = (shift_reg[7:1] == ownAddr) & readyS & ~busyS;
  assign readByte  = (pointer_reg == STATUS_OFFSET) ? protectionStatus : regRdData;
  // Loading the status byte for sending is the read that clears
  assign statusRdClr = (state_reg == ST_RX) & sclFall & inAck_reg & isRead_reg &
                       (byteNum_reg == 2'd1) & (pointer_reg == STATUS_OFFSET) |
                       (state_reg == ST_TX) & sclFall & inAck_reg & masterAck_reg &
                       (pointer_reg == STATUS_OFFSET);

  assign link.sdaDevOut = 1'b0;
  assign link.sdaDevOe  = sdaOe_reg;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg     <= ST_IDLE;
      bitCnt_reg    <= 4'h0;
      byteNum_reg   <= 2'd0;
      shift_reg     <= 8'h00;
      pointer_reg   <= 8'h00;
      inAck_reg     <= 1'b0;
      isRead_reg    <= 1'b0;
      masterAck_reg <= 1'b0;
      sdaOe_reg     <= 1'b0;
      regWrStrobe   <= 1'b0;
      regWrAddr     <= 8'h00;
      regWrData     <= 8'h00;
    end else begin
      regWrStrobe <= 1'b0;
      if (stopSeen || !readyS) begin
        state_reg <= ST_IDLE;
        sdaOe_reg <= 1'b0;
        inAck_reg <= 1'b0;
      end else if (startSeen) begin
        state_reg   <= ST_RX;
        bitCnt_reg  <= 4'h0;
        byteNum_reg <= 2'd0;
        inAck_reg   <= 1'b0;
        sdaOe_reg   <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            sdaOe_reg <= 1'b0;
          end
          ST_RX: begin
            if (sclRise && !inAck_reg && bitCnt_reg < 4'h8) begin
              shift_reg  <= {shift_reg[6:0], sdaS};
              bitCnt_reg <= bitCnt_reg + 4'h1;
            end else if (sclFall && inAck_reg) begin
              inAck_reg  <= 1'b0;
              bitCnt_reg <= 4'h0;
              if (byteNum_reg == 2'd1 && isRead_reg) begin
                state_reg   <= ST_TX;
                shift_reg   <= readByte;
                sdaOe_reg   <= ~readByte[7];
                pointer_reg <= pointer_reg + 8'h01;
              end else begin
                sdaOe_reg <= 1'b0;
              end
            end else if (sclFall && bitCnt_reg == 4'h8) begin
              inAck_reg <= 1'b1;
              sdaOe_reg <= 1'b1;
              if (byteNum_reg != 2'd3) begin
                byteNum_reg <= byteNum_reg + 2'd1;
              end
              if (byteNum_reg == 2'd0) begin
                isRead_reg <= shift_reg[0];
                if (!addrMatch) begin
                  state_reg <= ST_IDLE;
                  inAck_reg <= 1'b0;
                  sdaOe_reg <= 1'b0;
                end
              end else if (byteNum_reg == 2'd1) begin
                pointer_reg <= shift_reg;
              end else begin
                regWrStrobe <= (pointer_reg != STATUS_OFFSET);
                regWrAddr   <= pointer_reg;
                regWrData   <= shift_reg;
                pointer_reg <= pointer_reg + 8'h01;
              end
            end
          end
          ST_TX: begin
            if (sclRise) begin
              if (inAck_reg) begin
                masterAck_reg <= ~sdaS;
              end else begin
                bitCnt_reg <= bitCnt_reg + 4'h1;
              end
            end else if (sclFall) begin
              if (inAck_reg) begin
                inAck_reg  <= 1'b0;
                bitCnt_reg <= 4'h0;
                if (masterAck_reg) begin
                  shift_reg   <= readByte;
                  sdaOe_reg   <= ~readByte[7];
                  pointer_reg <= pointer_reg + 8'h01;
                end else begin
                  state_reg <= ST_IDLE;
                  sdaOe_reg <= 1'b0;
                end
              end else if (bitCnt_reg == 4'h8) begin
                inAck_reg <= 1'b1;
                sdaOe_reg <= 1'b0;
              end else begin
                sdaOe_reg <= ~shift_reg[6];
                shift_reg <= {shift_reg[6:0], 1'b0};
              end
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// >>> rtl/pmx_i2c_host.sv
// Host end: Wishbone-controlled byte engine that masters the two-wire link.
// Assumes software issues one command at a time and polls the busy bit.
`timescale 1ns/1ns
module pmx_i2c_host
  import pmx_pkg::*;
#(
  parameter int HALF_CYC = SCL_HALF_CYC
)
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Wishbone slave
  input  wire logic        cyc,
  input  wire logic        stb,
  input  wire logic        we,
  input  wire logic [3:0]  adr,
  input  wire logic [3:0]  sel,
  input  wire logic [31:0] datWr,
  output logic [31:0]      datRd,
  output logic             ack,
  // Serial link
  pmx_i2c_if.host          link
);

  typedef enum logic [2:0] {
    HS_IDLE, HS_START_A, HS_START_B, HS_BIT_LOW, HS_BIT_HIGH, HS_STOP_A, HS_STOP_B,
    HS_STOP_C
  } pmx_host_state_t;

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers
  logic [1:0] syncA_reg;
  logic [1:0] syncB_reg;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      syncA_reg <= 2'h3;
      syncB_reg <= 2'h3;
    end else begin
      syncA_reg <= {link.scl, link.sda};
      syncB_reg <= syncA_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Wishbone registers
  pmx_host_state_t state_reg;
  logic [4:0]      cmd_reg;
  logic [7:0]      txd_reg;
  logic [7:0]      rxd_reg;
  logic            acked_reg;
  logic            go;
  logic            busy;

  assign busy = (state_reg != HS_IDLE);
  assign go   = cyc & stb & ~ack & we & sel[0] & (adr == HOST_CMD_OFS) & ~busy;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ack     <= 1'b0;
      datRd   <= 32'h0000_0000;
      cmd_reg <= 5'h00;
      txd_reg <= 8'h00;
    end else begin
      ack <= cyc & stb & ~ack;
      if (go) begin
        cmd_reg <= datWr[4:0];
      end
      if (cyc && stb && !ack && we && sel[0] && adr == HOST_TXD_OFS) begin
        txd_reg <= datWr[7:0];
      end
      case (adr)
        HOST_CMD_OFS:  datRd <= {27'h0, cmd_reg};
        HOST_TXD_OFS:  datRd <= {24'h0, txd_reg};
        HOST_STAT_OFS: datRd <= {16'h0, rxd_reg, 6'h00, acked_reg, busy};
        default:       datRd <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bit engine
  logic [15:0] timer_reg;
  logic [3:0]  bitIdx_reg;
  logic [7:0]  shift_reg;
  logic        sclLow_reg;
  logic        sdaLow_reg;
  logic        tick;

  assign tick = (timer_reg == 16'h0000);
  assign link.sclHostOut = 1'b0;
  assign link.sclHostOe  = sclLow_reg;
  assign link.sdaHostOut = 1'b0;
  assign link.sdaHostOe  = sdaLow_reg;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg  <= HS_IDLE;
      timer_reg  <= 16'h0000;
      bitIdx_reg <= 4'h0;
      shift_reg  <= 8'h00;
      rxd_reg    <= 8'h00;
      acked_reg  <= 1'b0;
      sclLow_reg <= 1'b0;
      sdaLow_reg <= 1'b0;
    end else begin
      if (!tick) begin
        timer_reg <= timer_reg - 16'h0001;
      end
      case (state_reg)
        HS_IDLE: begin
          if (go) begin
            timer_reg  <= 16'(HALF_CYC - 1);
            bitIdx_reg <= 4'h0;
            shift_reg  <= txd_reg;
            if (datWr[CMD_START]) begin
              state_reg  <= HS_START_A;
              sdaLow_reg <= 1'b1;
            end else if (datWr[CMD_WRITE] || datWr[CMD_READ]) begin
              state_reg <= HS_BIT_LOW;
            end else if (datWr[CMD_STOP]) begin
              state_reg <= HS_STOP_A;
            end
          end
        end
        HS_START_A: begin
          if (tick) begin
            sclLow_reg <= 1'b1;
            timer_reg  <= 16'(HALF_CYC - 1);
            state_reg  <= (cmd_reg[CMD_WRITE] | cmd_reg[CMD_READ]) ? HS_BIT_LOW :
                          (cmd_reg[CMD_STOP] ? HS_STOP_A : HS_IDLE);
          end
        end
        HS_BIT_LOW: begin
          sclLow_reg <= 1'b1;
          if (tick) begin
            if (bitIdx_reg == 4'h8) begin
              sdaLow_reg <= cmd_reg[CMD_READ] & ~cmd_reg[CMD_NACK];
            end else begin
              sdaLow_reg <= cmd_reg[CMD_WRITE] & ~shift_reg[7];
            end
            timer_reg <= 16'(HALF_CYC - 1);
            state_reg <= HS_START_B;
          end
        end
        HS_START_B: begin
          // Settle SDA before releasing SCL
          if (tick) begin
            sclLow_reg <= 1'b0;
            timer_reg  <= 16'(HALF_CYC - 1);
            state_reg  <= HS_BIT_HIGH;
          end
        end
        HS_BIT_HIGH: begin
          // three half periods per bit keep rate below limit
          if (tick) begin
            sclLow_reg <= 1'b1;
            timer_reg  <= 16'(HALF_CYC - 1);
            if (bitIdx_reg == 4'h8) begin
              acked_reg  <= ~syncB_reg[0];
              rxd_reg    <= cmd_reg[CMD_READ] ? shift_reg : rxd_reg;
              sdaLow_reg <= cmd_reg[CMD_STOP];
              state_reg  <= cmd_reg[CMD_STOP] ? HS_STOP_A : HS_IDLE;
            end else begin
              shift_reg  <= {shift_reg[6:0], syncB_reg[0]};
              bitIdx_reg <= bitIdx_reg + 4'h1;
              state_reg  <= HS_BIT_LOW;
            end
          end
        end
        HS_STOP_A: begin
          sclLow_reg <= 1'b1;
          sdaLow_reg <= 1'b1;
          if (tick) begin
            timer_reg <= 16'(HALF_CYC - 1);
            state_reg <= HS_STOP_B;
          end
        end
        HS_STOP_B: begin
          sclLow_reg <= 1'b0;
          if (tick) begin
            timer_reg <= 16'(HALF_CYC - 1);
            state_reg <= HS_STOP_C;
          end
        end
        HS_STOP_C: begin
          sdaLow_reg <= 1'b0;
          if (tick) begin
            state_reg <= HS_IDLE;
          end
        end
        default: begin
          state_reg <= HS_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> bench/pmx_i2c_chk.sv
// Wire checker for the two-wire status link.
// Assumes it watches the resolved wires and enables of one link instance.
`timescale 1ns/1ns
module pmx_i2c_chk
  import pmx_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic sdaHostOe,
  input wire logic sdaDevOe
);
////////////////////////////////////////////////////////////////////////////////
  logic       sclQ;
  logic       sdaQ;
  logic       busyReg;
  logic       rdMode;
  logic [3:0] bitCnt;
  logic [3:0] byteCnt;
  logic [7:0] sh;
  wire        start = sclQ & scl & sdaQ & ~sda;
  wire        stop  = sclQ & scl & ~sdaQ & sda;
  wire        rise  = ~sclQ & scl;

  always_ff @(posedge core_clk) begin
    sclQ <= scl;
    sdaQ <= sda;
    busyReg <= (!rst_n || stop) ? 1'h0 : (start ? 1'h1 : busyReg);
  end

  // Bit slot 8 is the ninth clock of a byte
  always_ff @(posedge core_clk) begin
    if (!rst_n || start) begin
      bitCnt <= 4'h0;
      byteCnt <= 4'h0;
      rdMode <= 1'h0;
    end else if (rise) begin
      sh <= {sh[6:0], sda};
      bitCnt <= (bitCnt == 4'h8) ? 4'h0 : bitCnt + 4'h1;
      if (bitCnt == 4'h8) byteCnt <= byteCnt + 4'h1;
      if (byteCnt == 4'h0 && bitCnt == 4'h7) rdMode <= sda;
    end
  end
////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  idle_release_a: assert property (!busyReg |-> !sdaDevOe)
    else $error("device pulls data outside a transfer");
  host_start_a: assert property (start |-> sdaHostOe)
    else $error("start not made by the host");
  hold_high_a: assert property (sclQ && scl |-> $stable(sdaDevOe))
    else $error("device data moved while clock high");
  ack_release_a: assert property ($fell(scl) && sdaDevOe && !rdMode |-> ##[1:8] !sdaDevOe)
    else $error("device ack not released");
  ack_slot_a: assert property (rise && sdaDevOe && !rdMode |-> bitCnt == 4'h8)
    else $error("device drove outside the ninth clock");
  addr_fixed_a: assert property (rise && byteCnt == 4'h0 && bitCnt == 4'h8 && sdaDevOe
    |-> sh[7:3] == ADDR_FIXED_HI)
    else $error("ack on a foreign address");
  master_ack_a: assert property (rise && rdMode && byteCnt != 4'h0 && bitCnt == 4'h8
    |-> !sdaDevOe)
    else $error("device held the master ack slot");
  rd_dir_a: assert property (rise && rdMode && byteCnt != 4'h0 && bitCnt != 4'h8
    && bitCnt != 4'h0 |-> !sdaHostOe)
    else $error("host drove data in a read");
endmodule

// >>> bench/power_mux_i2c_status_slave_bench.sv
// Bench: host end and device end joined by one link, driven over Wishbone.
// Assumes the host answers each Wishbone request one cycle later.
`timescale 1ns/1ns
module power_mux_i2c_status_slave_bench
  import pmx_pkg::*;
;
  localparam int HC = 10;
  localparam logic [7:0] ST = 8'h01 << CMD_START;
  localparam logic [7:0] SP = 8'h01 << CMD_STOP;
  localparam logic [7:0] WR = 8'h01 << CMD_WRITE;
  localparam logic [7:0] RD = 8'h01 << CMD_READ;
  localparam logic [7:0] NK = 8'h01 << CMD_NACK;
  logic core_clk = 1'h0, rst_n = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0, ack;
  logic [3:0] adr = 4'h0, sel = 4'hF;
  logic [31:0] datWr = 32'h0, datRd;
  logic [1:0] addrStrap = 2'h0;
  logic supplyOk = 1'h1, seqBusy = 1'h0, hvOverCurrent = 1'h0, reverseCond = 1'h0;
  logic lowvOverCurrent = 1'h0, busOver6v = 1'h0, busOverThresh = 1'h0, hvChannelSel = 1'h0;
  logic busBelowSwap = 1'h0, swapEnable = 1'h0, dieHot = 1'h0, dieCooled = 1'h0;
  logic busIn5vWindow = 1'h0, busNearZero = 1'h0, reverseAlertMask = 1'h0;
  logic alert_n, powerOff, roleSwapPulse, regWrStrobe;
  logic [7:0] protectionStatus, regWrAddr, regWrData, lastA, lastD;
  logic [7:0] regRdData = 8'h00;
  int nFail = 0, totalChecks = 0, nStrobe = 0, nPulse = 0;

  pmx_i2c_if link();
  pmx_i2c_host #(.HALF_CYC(HC)) u_pmx_i2c_host (.core_clk, .rst_n, .cyc, .stb, .we, .adr,
    .sel, .datWr, .datRd, .ack, .link(link));
  pmx_i2c_dev u_pmx_i2c_dev (.core_clk, .rst_n, .link(link), .addrStrap, .supplyOk, .seqBusy,
    .hvOverCurrent, .reverseCond, .lowvOverCurrent, .busOver6v, .busOverThresh, .hvChannelSel,
    .busBelowSwap, .swapEnable, .dieHot, .dieCooled, .busIn5vWindow, .busNearZero,
    .reverseAlertMask, .alert_n, .powerOff, .roleSwapPulse, .protectionStatus, .regWrStrobe,
    .regWrAddr, .regWrData, .regRdData);
  pmx_i2c_chk u_pmx_i2c_chk (.core_clk, .rst_n, .scl(link.scl), .sda(link.sda),
    .sdaHostOe(link.sdaHostOe), .sdaDevOe(link.sdaDevOe));

  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (roleSwapPulse === 1'h1) nPulse++;
    if (regWrStrobe === 1'h1) begin
      nStrobe++;
      lastA = regWrAddr;
      lastD = regWrData;
    end
  end
////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int i;
    @(posedge core_clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    datWr <= d;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (ack !== 1'h1 && i < 50);
    if (ack !== 1'h1) begin
      nFail++;
      conclude();
    end
    q = datRd;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask

  // One byte on the link, then poll until the engine is idle
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] txd, output logic [31:0] st);
    int i;
    wb(1'h1, HOST_TXD_OFS, {24'h0, txd}, st);
    wb(1'h1, HOST_CMD_OFS, {24'h0, cmd}, st);
    for (i = 0; i < 400; i++) begin
      wb(1'h0, HOST_STAT_OFS, 32'h0, st);
      if (st[STAT_BUSY] === 1'h0) break;
    end
    if (i == 400) begin
      nFail++;
      conclude();
    end
  endtask

  task automatic probe(input logic [1:0] s, input logic expAck);
    logic [31:0] st;
    xfer(ST | WR | SP, {ADDR_FIXED_HI, s, 1'h0}, st);
    check(st[STAT_ACKED], expAck);
  endtask

  task automatic setPtr(input logic [7:0] p);
    logic [31:0] st;
    xfer(ST | WR, {ADDR_FIXED_HI, addrStrap, 1'h0}, st);
    xfer(WR | SP, p, st);
    check(st[STAT_ACKED], 1'h1);
  endtask

  task automatic readStat(input logic [7:0] exp);
    logic [31:0] st;
    setPtr(8'h00);
    xfer(ST | WR, {ADDR_FIXED_HI, addrStrap, 1'h1}, st);
    xfer(RD | NK | SP, 8'h00, st);
    check(st[15:8], exp);
  endtask
////////////////////////////////////////////////////////////////////////////////
  task automatic strapScen();
    for (int s = 0; s < 4; s++) begin
      addrStrap <= s[1:0];
      repeat (6) @(posedge core_clk);
      probe(s[1:0], 1'h1);
      probe(~s[1:0], 1'h0);
    end
  endtask

  task automatic writeScen();
    logic [31:0] st;
    xfer(ST | WR, {ADDR_FIXED_HI, addrStrap, 1'h0}, st);
    xfer(WR, 8'h03, st);
    xfer(WR, 8'hA5, st);
    xfer(WR | SP, 8'h5A, st);
    check({nStrobe[7:0], lastA, lastD}, {8'h02, 8'h04, 8'h5A});
    xfer(ST | WR, {ADDR_FIXED_HI, addrStrap, 1'h0}, st);
    xfer(WR, 8'h00, st);
    xfer(WR | SP, 8'hFF, st);
    check({nStrobe[7:0], protectionStatus}, {8'h02, 8'h00});
  endtask

  task automatic flagScen();
    {hvOverCurrent, reverseCond, lowvOverCurrent, busOver6v, busBelowSwap} <= 5'h1F;
    {swapEnable, dieHot, busIn5vWindow, busNearZero, reverseAlertMask} <= 5'h1F;
    repeat (8) @(posedge core_clk);
    check({protectionStatus, alert_n, powerOff}, {8'hFF, 2'h1});
    check(nPulse, 32'h1);
    {hvOverCurrent, lowvOverCurrent, busOver6v, busBelowSwap, dieHot} <= 5'h00;
    repeat (8) @(posedge core_clk);
    readStat(8'hFF);
    check({protectionStatus, alert_n}, {8'h47, 1'h0});
    dieCooled <= 1'h1;
    readStat(8'h47);
    check({protectionStatus, alert_n, powerOff}, {8'h43, 2'h2});
    reverseAlertMask <= 1'h0;
    repeat (8) @(posedge core_clk);
    check(alert_n, 1'h0);
    reverseCond <= 1'h0;
    readStat(8'h43);
    check({protectionStatus, alert_n}, {8'h03, 1'h1});
    {hvChannelSel, busOver6v} <= 2'h3;
    repeat (8) @(posedge core_clk);
    check({protectionStatus, powerOff}, {8'h03, 1'h0});
    busOverThresh <= 1'h1;
    repeat (8) @(posedge core_clk);
    check({protectionStatus, alert_n, powerOff}, {8'h13, 2'h3});
  endtask

  task automatic gateScen();
    supplyOk <= 1'h0;
    repeat (6) @(posedge core_clk);
    probe(addrStrap, 1'h0);
    supplyOk <= 1'h1;
    seqBusy <= 1'h1;
    repeat (6) @(posedge core_clk);
    probe(addrStrap, 1'h0);
    seqBusy <= 1'h0;
    repeat (6) @(posedge core_clk);
    probe(addrStrap, 1'h1);
  endtask

  // Two edges of reset; synchronisers reset to idle levels
  initial begin
    repeat (2) @(posedge core_clk);
    check({alert_n, powerOff, protectionStatus}, {2'h2, STATUS_RESET});
    rst_n <= 1'h1;
    strapScen();
    writeScen();
    flagScen();
    gateScen();
    conclude();
  end
endmodule
